// ===== shared/dpdci_pkg.sv
// Constants and types shared by the dual port converter front end
package dpdci_pkg;
    localparam int unsigned CODE_W = 10;
    localparam int unsigned MSB_W = 5;
    localparam int unsigned MID_W = 4;
    localparam int unsigned MSB_SEGS = 31;
    localparam int unsigned MID_SEGS = 15;
    localparam int unsigned MSB_POS = 5;
    localparam int unsigned MID_POS = 1;
    localparam int unsigned LSB_POS = 0;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned LOCK_CNT_W = 4;
    localparam logic [CODE_W-1:0] CODE_RST = 10'h000;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
    localparam logic [3:0] RATIO_RST = 4'h1;
    // Matching spans needed before lock is declared
    localparam logic [LOCK_CNT_W-1:0] LOCK_SPANS = 4'h4;
    // Span mismatch in clk cycles still treated as in phase
    localparam logic [CNT_W-1:0] SPAN_TOL = 16'h0001;
    localparam logic [1:0] SEL_RANGE_SELECT_HIGH = 2'h0;
    localparam logic [1:0] SEL_DIV2 = 2'h1;
    localparam logic [1:0] SEL_DIV4 = 2'h2;
    localparam logic [1:0] SEL_DIV8 = 2'h3;
    localparam logic [3:0] RATIO_1 = 4'h1;
    localparam logic [3:0] RATIO_2 = 4'h2;
    localparam logic [3:0] RATIO_4 = 4'h4;
    localparam logic [3:0] RATIO_8 = 4'h8;
    localparam int unsigned SYNC_W = 25;

    typedef enum logic [1:0] {
        DPDCI_LK_OFF = 2'b00,
        DPDCI_LK_ACQ = 2'b01,
        DPDCI_LK_LOCK = 2'b11
    } dpdci_lock_e;
endpackage : dpdci_pkg

// ===== shared/dpdci_seg_if.sv
// Carrier between the sample path and the segment decoder
`timescale 1ns/100ps
interface dpdci_seg_if;
    logic [dpdci_pkg::CODE_W-1:0] code;
    logic [dpdci_pkg::MSB_SEGS-1:0] msb_true;
    logic [dpdci_pkg::MSB_SEGS-1:0] msb_comp;
    logic [dpdci_pkg::MID_SEGS-1:0] mid_true;
    logic [dpdci_pkg::MID_SEGS-1:0] mid_comp;
    logic lsb_true;
    logic lsb_comp;

    modport src (
        output code,
        input msb_true,
        input msb_comp,
        input mid_true,
        input mid_comp,
        input lsb_true,
        input lsb_comp
    );
    modport dec (
        input code,
        output msb_true,
        output msb_comp,
        output mid_true,
        output mid_comp,
        output lsb_true,
        output lsb_comp
    );
endinterface : dpdci_seg_if

// ===== src/dpdci_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module dpdci_sync #(
    parameter int unsigned W = dpdci_pkg::SYNC_W
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_dout;

    always_comb begin
        next_meta = din;
        next_dout = meta;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= next_meta;
            dout <= next_dout;
        end
    end
endmodule : dpdci_sync

// ===== src/dpdci_decoder.sv
// Segment decoder: code to thermometer switch controls, registered
`timescale 1ns/100ps
module dpdci_decoder (
    input wire logic clk,
    input wire logic sys_rst,
    dpdci_seg_if.dec seg
);
    logic [dpdci_pkg::MSB_W-1:0] msb_field;
    logic [dpdci_pkg::MID_W-1:0] mid_field;
    logic [dpdci_pkg::MSB_SEGS-1:0] next_msb;
    logic [dpdci_pkg::MID_SEGS-1:0] next_mid;
    logic next_lsb;
    logic [dpdci_pkg::MSB_SEGS-1:0] msb_q;
    logic [dpdci_pkg::MID_SEGS-1:0] mid_q;
    logic lsb_q;

    assign msb_field = seg.code[dpdci_pkg::MSB_POS +: dpdci_pkg::MSB_W];
    assign mid_field = seg.code[dpdci_pkg::MID_POS +: dpdci_pkg::MID_W];

    genvar i;
    generate
        for (i = 0; i < dpdci_pkg::MSB_SEGS; i++) begin : g_msb
            assign next_msb[i] = (msb_field > 5'(i));
        end
        for (i = 0; i < dpdci_pkg::MID_SEGS; i++) begin : g_mid
            assign next_mid[i] = (mid_field > 4'(i));
        end
    endgenerate

    always_comb begin
        next_lsb = seg.code[dpdci_pkg::LSB_POS];
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            msb_q <= '0;
            mid_q <= '0;
            lsb_q <= 1'b0;
        end else begin
            msb_q <= next_msb;
            mid_q <= next_mid;
            lsb_q <= next_lsb;
        end
    end

    // Complement taken from the same flop so a source is never on both or neither side
    assign seg.msb_true = msb_q;
    assign seg.msb_comp = ~msb_q;
    assign seg.mid_true = mid_q;
    assign seg.mid_comp = ~mid_q;
    assign seg.lsb_true = lsb_q;
    assign seg.lsb_comp = ~lsb_q;
endmodule : dpdci_decoder

// ===== src/dpdci_front.sv
// Dual port converter front end: capture, clock multiplier emulation, lock and decode
// Contract
// - With the multiplier supply pin high the block runs in multiplier mode, timing derived from the sample clock.
// - In multiplier mode both ports are captured together on one rising edge of the sample clock.
// - The loop yields two output latch loads per input period, acting as a doubled clock.
// - The range selects choose the prescaler ratio 1, 2, 4 or 8 for codes 00, 01, 10, 11.
// - In multiplier mode the lock indicator comes from the phase comparison and is 1 when locked.
// - The top five code bits drive 31 equal segments in thermometer form.
// - The next four code bits drive 15 equal segments of one sixteenth weight in thermometer form.
// - The lowest code bit drives one binary weighted source directly.
// - Each segment control steers to exactly one of the true and complement outputs.
// - Latches and decoding are simple registered stages that sustain full conversion rate.
// - On each sample clock rise the output latch loads port two, half a period later port one.
// - Codes are straight binary 0 to 1023 and all ones puts current on the true output.
`timescale 1ns/100ps
module dpdci_front (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sample_clk,
    input wire logic multiplier_supply_pin,
    input wire logic range_select_low,
    input wire logic range_select_high,
    input wire logic divider_reset,
    input wire logic [dpdci_pkg::CODE_W-1:0] port1_data,
    input wire logic [dpdci_pkg::CODE_W-1:0] port2_data,
    output logic lock_indicator,
    output logic [dpdci_pkg::CODE_W-1:0] output_code,
    output logic [dpdci_pkg::MSB_SEGS-1:0] true_current_output_msb,
    output logic [dpdci_pkg::MSB_SEGS-1:0] complement_current_output_msb,
    output logic [dpdci_pkg::MID_SEGS-1:0] true_current_output_mid,
    output logic [dpdci_pkg::MID_SEGS-1:0] complement_current_output_mid,
    output logic true_current_output_lsb,
    output logic complement_current_output_lsb
);
    // Ratio decode from the two range select levels
    function automatic logic [3:0] dpdci_ratio(input logic [1:0] sel);
        logic [3:0] r;
        r = dpdci_pkg::RATIO_1;
        unique case (sel)
            dpdci_pkg::SEL_RANGE_SELECT_HIGH: r = dpdci_pkg::RATIO_1;
            dpdci_pkg::SEL_DIV2: r = dpdci_pkg::RATIO_2;
            dpdci_pkg::SEL_DIV4: r = dpdci_pkg::RATIO_4;
            dpdci_pkg::SEL_DIV8: r = dpdci_pkg::RATIO_8;
        endcase
        return r;
    endfunction : dpdci_ratio

    logic [dpdci_pkg::SYNC_W-1:0] sync_in;
    logic [dpdci_pkg::SYNC_W-1:0] sync_out;
    logic sclk_s;
    logic mode_s;
    logic [1:0] sel_s;
    logic [dpdci_pkg::CODE_W-1:0] p1_s;
    logic [dpdci_pkg::CODE_W-1:0] p2_s;
    logic rst_pin_s;

    // The divider reset pin is synchronised but has no effect in multiplier mode
    // Words and the sample clock share one synchroniser, so a word and its edge land in the same cycle
    assign sync_in = {
        divider_reset,
        range_select_high,
        range_select_low,
        multiplier_supply_pin,
        sample_clk,
        port2_data,
        port1_data
    };

    dpdci_sync #(.W(dpdci_pkg::SYNC_W)) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(sync_in),
        .dout(sync_out)
    );

    assign p1_s = sync_out[9:0];
    assign p2_s = sync_out[19:10];
    assign sclk_s = sync_out[20];
    assign mode_s = sync_out[21];
    assign sel_s = sync_out[23:22];
    localparam int unsigned SYNC_W_TOP = dpdci_pkg::SYNC_W - 1;
    assign rst_pin_s = sync_out[SYNC_W_TOP];

    dpdci_seg_if seg ();

    dpdci_decoder u_dec (
        .clk(clk),
        .sys_rst(sys_rst),
        .seg(seg.dec)
    );

    // Sample clock edge and rise-to-rise period in clk cycles
    logic sclk_d;
    logic rise;
    logic [dpdci_pkg::CNT_W-1:0] cnt;
    logic [dpdci_pkg::CNT_W-1:0] period;
    logic next_sclk_d;
    logic [dpdci_pkg::CNT_W-1:0] next_cnt;
    logic [dpdci_pkg::CNT_W-1:0] next_period;
    logic [dpdci_pkg::CNT_W-1:0] cnt_inc;
    logic [dpdci_pkg::CNT_W-1:0] half_mark;

    // Saturating so a stopped sample clock never wraps into a false short period
    assign rise = sclk_s & ~sclk_d;
    assign cnt_inc = (cnt == dpdci_pkg::CNT_MAX) ? cnt : cnt + 16'h0001;
    // Mid-period load follows the measured period, not the duty cycle of the pin
    assign half_mark = period >> 1;

    always_comb begin
        next_sclk_d = sclk_s;
        next_cnt = cnt_inc;
        next_period = period;
        if (rise) begin
            next_cnt = dpdci_pkg::CNT_RST;
            next_period = cnt_inc;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sclk_d <= 1'b0;
            cnt <= dpdci_pkg::CNT_RST;
            period <= dpdci_pkg::CNT_RST;
        end else begin
            sclk_d <= next_sclk_d;
            cnt <= next_cnt;
            period <= next_period;
        end
    end

    // Input latches: both ports on the same detected rise
    logic [dpdci_pkg::CODE_W-1:0] p1_lat;
    logic [dpdci_pkg::CODE_W-1:0] p2_lat;
    logic [dpdci_pkg::CODE_W-1:0] next_p1_lat;
    logic [dpdci_pkg::CODE_W-1:0] next_p2_lat;

    always_comb begin
        next_p1_lat = p1_lat;
        next_p2_lat = p2_lat;
        if (mode_s && rise) begin
            next_p1_lat = p1_s;
            next_p2_lat = p2_s;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            p1_lat <= dpdci_pkg::CODE_RST;
            p2_lat <= dpdci_pkg::CODE_RST;
        end else begin
            p1_lat <= next_p1_lat;
            p2_lat <= next_p2_lat;
        end
    end

    // Output latch: port two on the rise, port one at mid period
    logic [dpdci_pkg::CODE_W-1:0] out_lat;
    logic half_pend;
    logic [dpdci_pkg::CODE_W-1:0] next_out_lat;
    logic next_half_pend;

    always_comb begin
        next_out_lat = out_lat;
        next_half_pend = half_pend;
        if (!mode_s) begin
            next_half_pend = 1'b0;
        end else if (rise) begin
            next_out_lat = p2_lat;
            next_half_pend = 1'b1;
        end else if (half_pend && cnt_inc >= half_mark) begin
            // Mid-period load, the second update of the doubled clock
            next_out_lat = p1_lat;
            next_half_pend = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_lat <= dpdci_pkg::CODE_RST;
            half_pend <= 1'b0;
        end else begin
            out_lat <= next_out_lat;
            half_pend <= next_half_pend;
        end
    end

    // Lock detection: spans of ratio periods compared edge to edge
    dpdci_pkg::dpdci_lock_e lk_state;
    dpdci_pkg::dpdci_lock_e next_lk_state;
    logic [3:0] pre_cnt;
    logic [3:0] next_pre_cnt;
    logic [dpdci_pkg::CNT_W-1:0] span;
    logic [dpdci_pkg::CNT_W-1:0] next_span;
    logic [dpdci_pkg::CNT_W-1:0] last_span;
    logic [dpdci_pkg::CNT_W-1:0] next_last_span;
    logic [dpdci_pkg::LOCK_CNT_W-1:0] match_cnt;
    logic [dpdci_pkg::LOCK_CNT_W-1:0] next_match_cnt;
    logic [3:0] ratio;
    logic span_end;
    logic in_phase;
    logic [dpdci_pkg::CNT_W-1:0] span_inc;
    logic [dpdci_pkg::CNT_W-1:0] span_diff;

    assign ratio = dpdci_ratio(sel_s);
    assign span_end = rise && (pre_cnt + 4'h1 >= ratio);
    assign span_inc = (span == dpdci_pkg::CNT_MAX) ? span : span + 16'h0001;
    assign span_diff = (span_inc > last_span) ? span_inc - last_span : last_span - span_inc;
    assign in_phase = (last_span != dpdci_pkg::CNT_RST) && (span_diff <= dpdci_pkg::SPAN_TOL);

    always_comb begin
        next_pre_cnt = pre_cnt;
        next_span = span_inc;
        next_last_span = last_span;
        next_match_cnt = match_cnt;
        next_lk_state = lk_state;
        if (rise) begin
            next_pre_cnt = span_end ? 4'h0 : pre_cnt + 4'h1;
        end
        if (span_end) begin
            next_span = dpdci_pkg::CNT_RST;
            next_last_span = span_inc;
        end
        unique case (lk_state)
            dpdci_pkg::DPDCI_LK_OFF: begin
                next_match_cnt = '0;
                if (mode_s) begin
                    next_lk_state = dpdci_pkg::DPDCI_LK_ACQ;
                end
            end
            dpdci_pkg::DPDCI_LK_ACQ: begin
                if (!mode_s) begin
                    next_lk_state = dpdci_pkg::DPDCI_LK_OFF;
                end else if (span_end) begin
                    if (!in_phase) begin
                        next_match_cnt = '0;
                    end else if (match_cnt + 4'h1 >= dpdci_pkg::LOCK_SPANS) begin
                        next_lk_state = dpdci_pkg::DPDCI_LK_LOCK;
                    end else begin
                        next_match_cnt = match_cnt + 4'h1;
                    end
                end
            end
            dpdci_pkg::DPDCI_LK_LOCK: begin
                if (!mode_s) begin
                    next_lk_state = dpdci_pkg::DPDCI_LK_OFF;
                end else if (span_end && !in_phase) begin
                    // One slipped span drops lock and acquisition restarts
                    next_match_cnt = '0;
                    next_lk_state = dpdci_pkg::DPDCI_LK_ACQ;
                end
            end
            default: begin
                next_lk_state = dpdci_pkg::DPDCI_LK_OFF;
            end
        endcase
        if (!mode_s) begin
            next_pre_cnt = 4'h0;
            next_last_span = dpdci_pkg::CNT_RST;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lk_state <= dpdci_pkg::DPDCI_LK_OFF;
            pre_cnt <= 4'h0;
            span <= dpdci_pkg::CNT_RST;
            last_span <= dpdci_pkg::CNT_RST;
            match_cnt <= '0;
        end else begin
            lk_state <= next_lk_state;
            pre_cnt <= next_pre_cnt;
            span <= next_span;
            last_span <= next_last_span;
            match_cnt <= next_match_cnt;
        end
    end

    // The pin is a flop of its own so a state decode never glitches onto it
    logic next_lock_indicator;

    always_comb begin
        next_lock_indicator = (next_lk_state == dpdci_pkg::DPDCI_LK_LOCK);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lock_indicator <= 1'b0;
        end else begin
            lock_indicator <= next_lock_indicator;
        end
    end

    // Output latch feeds the decoder; one registered stage keeps the path short
    assign seg.code = out_lat;
    assign output_code = out_lat;
    assign true_current_output_msb = seg.msb_true;
    assign complement_current_output_msb = seg.msb_comp;
    assign true_current_output_mid = seg.mid_true;
    assign complement_current_output_mid = seg.mid_comp;
    assign true_current_output_lsb = seg.lsb_true;
    assign complement_current_output_lsb = seg.lsb_comp;

    logic unused_rst_pin;
    assign unused_rst_pin = rst_pin_s;
endmodule : dpdci_front

// ===== tb/dpdci_front_properties.sv
// Port checker for the dual port converter front end
`timescale 1ns/100ps
module dpdci_front_properties (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic multiplier_supply_pin,
    input wire logic lock_indicator,
    input wire logic [dpdci_pkg::CODE_W-1:0] output_code,
    input wire logic [dpdci_pkg::MSB_SEGS-1:0] true_current_output_msb,
    input wire logic [dpdci_pkg::MSB_SEGS-1:0] complement_current_output_msb,
    input wire logic [dpdci_pkg::MID_SEGS-1:0] true_current_output_mid,
    input wire logic [dpdci_pkg::MID_SEGS-1:0] complement_current_output_mid,
    input wire logic true_current_output_lsb,
    input wire logic complement_current_output_lsb
);
    logic [31:0] exp_msb, next_exp_msb;
    logic [15:0] exp_mid, next_exp_mid;

    // Segments trail the output latch by one clock
    always_comb begin
        next_exp_msb = (32'h1 << output_code[9:5]) - 32'h1;
        next_exp_mid = (16'h1 << output_code[4:1]) - 16'h1;
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            exp_msb <= 32'h0;
            exp_mid <= 16'h0;
        end else begin
            exp_msb <= next_exp_msb;
            exp_mid <= next_exp_mid;
        end
    end

    a_msb_thermo: assert property (@(posedge clk) disable iff (sys_rst)
        true_current_output_msb == exp_msb[30:0]) else $error("msb segments wrong");
    a_mid_thermo: assert property (@(posedge clk) disable iff (sys_rst)
        true_current_output_mid == exp_mid[14:0]) else $error("mid segments wrong");
    a_lsb_direct: assert property (@(posedge clk) disable iff (sys_rst)
        true_current_output_lsb == $past(output_code[0])) else $error("lsb source wrong");
    a_msb_steer: assert property (@(posedge clk) disable iff (sys_rst)
        complement_current_output_msb == ~true_current_output_msb) else $error("msb steering wrong");
    a_mid_lsb_steer: assert property (@(posedge clk) disable iff (sys_rst)
        complement_current_output_mid == ~true_current_output_mid
        && complement_current_output_lsb == ~true_current_output_lsb) else $error("mid or lsb steering wrong");
    a_off_no_lock: assert property (@(posedge clk) disable iff (sys_rst)
        !multiplier_supply_pin [*6] |-> !lock_indicator) else $error("lock while mode off");
    a_off_no_load: assert property (@(posedge clk) disable iff (sys_rst)
        !multiplier_supply_pin [*6] |=> $stable(output_code)) else $error("load while mode off");
    a_lock_needs_mode: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(lock_indicator) |-> $past(multiplier_supply_pin, 3)) else $error("lock without mode");
    // The first edge of reset may race the asynchronous clear, so judge from the second on
    a_rst_values: assert property (@(posedge clk) sys_rst && $past(sys_rst) |->
        !lock_indicator && output_code == 10'h000 && &complement_current_output_msb) else $error("reset values");

    c_lock: cover property (@(posedge clk) disable iff (sys_rst) $rose(lock_indicator));
    c_full: cover property (@(posedge clk) disable iff (sys_rst) output_code == 10'h3FF);
    c_off: cover property (@(posedge clk) disable iff (sys_rst) !multiplier_supply_pin [*6]);
endmodule : dpdci_front_properties

bind dpdci_front dpdci_front_properties u_props (
    .clk, .sys_rst, .multiplier_supply_pin, .lock_indicator, .output_code,
    .true_current_output_msb, .complement_current_output_msb, .true_current_output_mid,
    .complement_current_output_mid, .true_current_output_lsb, .complement_current_output_lsb
);

// ===== tb/dpdci_source.sv
// Sample source model driving the applied clock and both ports
`timescale 1ns/100ps
module dpdci_source (
    input wire logic clk,
    input wire logic run,
    input wire logic [7:0] half,
    input wire logic [dpdci_pkg::CODE_W-1:0] word1,
    input wire logic [dpdci_pkg::CODE_W-1:0] word2,
    output logic sample_clk,
    output logic [dpdci_pkg::CODE_W-1:0] port1_data,
    output logic [dpdci_pkg::CODE_W-1:0] port2_data
);
    logic [7:0] cnt;
    logic run_q;
    logic [7:0] half_q;
    logic [dpdci_pkg::CODE_W-1:0] word1_q;
    logic [dpdci_pkg::CODE_W-1:0] word2_q;
    initial begin
        sample_clk = 1'b0;
        cnt = 8'h00;
        port1_data = 10'h000;
        port2_data = 10'h000;
    end
    always @(posedge clk) begin
        // Controls are taken at the edge, where the bench holds them steady
        run_q = run;
        half_q = half;
        word1_q = word1;
        word2_q = word2;
        #1;
        if (!run_q) begin
            // Idle: clock stands low, released ports toggle so no stale word is seen
            sample_clk <= 1'b0;
            cnt <= 8'h00;
            port1_data <= ~port1_data;
            port2_data <= ~port2_data;
        end else begin
            // New words at the start of the low phase, stable across the next rise
            if (cnt == 8'h00 && !sample_clk) begin
                port1_data <= word1_q;
                port2_data <= word2_q;
            end
            // Half period in clk cycles stands in for the band of the range
            if (cnt + 8'h01 >= half_q) begin
                sample_clk <= ~sample_clk;
                cnt <= 8'h00;
            end else begin
                cnt <= cnt + 8'h01;
            end
        end
    end
endmodule : dpdci_source

// ===== tb/dpdci_front_tb_top.sv
// Self-checking bench for the dual port converter front end
`timescale 1ns/100ps
module dpdci_front_tb_top;
    logic clk, sys_rst, mode, sel_lo, sel_hi, run, sclk, lock, tl, cl;
    logic [7:0] half;
    logic [dpdci_pkg::CODE_W-1:0] w1, w2, p1, p2, code;
    logic [dpdci_pkg::MSB_SEGS-1:0] tm, cm;
    logic [dpdci_pkg::MID_SEGS-1:0] td, cd;
    int num_errors, n_compared;

    dpdci_source src (.clk(clk), .run(run), .half(half), .word1(w1), .word2(w2),
        .sample_clk(sclk), .port1_data(p1), .port2_data(p2));
    dpdci_front DUT (.clk(clk), .sys_rst(sys_rst), .sample_clk(sclk), .multiplier_supply_pin(mode),
        .range_select_low(sel_lo), .range_select_high(sel_hi), .divider_reset(1'b0),
        .port1_data(p1), .port2_data(p2), .lock_indicator(lock), .output_code(code),
        .true_current_output_msb(tm), .complement_current_output_msb(cm),
        .true_current_output_mid(td), .complement_current_output_mid(cd),
        .true_current_output_lsb(tl), .complement_current_output_lsb(cl));

    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop

    task automatic do_reset();
        sys_rst = 1'b1;
        run = 1'b0;
        mode = 1'b0;
        repeat (20) tick();
        sys_rst = 1'b0;
        tick();
    endtask : do_reset

    task automatic test_reset();
        check(code, 10'h000, "code");
        check(tm, 31'h0, "true msb");
        check(cm, 31'h7FFFFFFF, "comp msb");
        check(cd, 15'h7FFF, "comp mid");
        check(td, 15'h0, "true mid");
        check(tl, 1'b0, "true lsb");
        check(cl, 1'b1, "comp lsb");
        check(lock, 1'b0, "lock");
        $display("test_reset done");
    endtask : test_reset

    task automatic test_interleave();
        logic [9:0] ws [10] = '{10'h001, 10'h3FF, 10'h200, 10'h01E, 10'h155,
            10'h2AA, 10'h0F0, 10'h30F, 10'h3E0, 10'h21F};
        logic [9:0] seen[$];
        int stamp[$];
        logic [9:0] last;
        logic prev, pend;
        int k;
        k = 0;
        last = code;
        prev = sclk;
        pend = 1'b0;
        w1 = ws[0];
        w2 = ws[1];
        half = 8'd6;
        mode = 1'b1;
        run = 1'b1;
        for (int c = 0; c < 300 && seen.size() < 10; c++) begin
            tick();
            if (pend) begin
                check(tm, (32'h1 << last[9:5]) - 32'h1, "msb segs");
                check(td, (16'h1 << last[4:1]) - 16'h1, "mid segs");
                check(tl, last[0], "lsb seg");
                if (last == 10'h3FF) check(cm, 31'h0, "full comp");
            end
            pend = (code !== last);
            if (pend) begin
                seen.push_back(code);
                stamp.push_back(c);
                last = code;
            end
            // Next pair goes out once the current pair has been taken
            if (sclk && !prev && k < 8) begin
                k = k + 2;
                w1 = ws[k];
                w2 = ws[k + 1];
            end
            prev = sclk;
        end
        check(seen.size(), 32'd10, "loads");
        if (seen.size() != 10) report_and_stop();
        for (int i = 0; i < 10; i++) check(seen[i], ws[i], "order");
        for (int i = 1; i < 9; i++) check(stamp[i + 1] - stamp[i], 32'd6, "half gap");
        $display("test_interleave done");
    endtask : test_interleave

    task automatic test_ranges();
        int n;
        int r;
        for (int s = 0; s < 4; s++) begin
            do_reset();
            r = 1 << s;
            sel_hi = s[1];
            sel_lo = s[0];
            half = 8'd4;
            mode = 1'b1;
            run = 1'b1;
            for (n = 0; n < 7 * r * 8 + 40 && lock !== 1'b1; n++) tick();
            check(n >= 3 * r * 8, 1'b1, "lock too early");
            check(lock, 1'b1, "lock");
            if (lock !== 1'b1) report_and_stop();
        end
        // Doubling the period breaks the span match
        half = 8'd8;
        for (n = 0; n < 400 && lock !== 1'b0; n++) tick();
        check(lock, 1'b0, "lock kept");
        $display("test_ranges done");
    endtask : test_ranges

    task automatic test_mode_off();
        logic [9:0] held;
        // Relock first so that dropping the mode pin has a lock to clear
        half = 8'd4;
        for (int n = 0; n < 700 && lock !== 1'b1; n++) tick();
        check(lock, 1'b1, "relock");
        mode = 1'b0;
        repeat (6) tick();
        held = code;
        repeat (40) begin
            tick();
            w1 = ~w1;
            w2 = w2 + 10'h001;
        end
        check(code, held, "code frozen");
        check(lock, 1'b0, "lock off");
        $display("test_mode_off done");
    endtask : test_mode_off

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        sys_rst = 1'b1;
        mode = 1'b0;
        run = 1'b0;
        sel_lo = 1'b0;
        sel_hi = 1'b0;
        half = 8'd4;
        w1 = 10'h000;
        w2 = 10'h000;
        num_errors = 0;
        n_compared = 0;
        do_reset();
        test_reset();
        test_interleave();
        test_ranges();
        test_mode_off();
        report_and_stop();
    end
endmodule : dpdci_front_tb_top
